/* File: logic/rbt_pkg.sv */
// constants shared by the registered bus transceiver
// Behaviour
// - low select passes live opposite bus, high select passes stored register
// - each capture clock rising edge loads its own side's bus into its register
// - drive B only while B enable high; drive A only while A enable low
// - both enables low, A select low: A bus follows B bus live
// - both enables low, A select high: A bus shows B-to-A register
// - both enables high, B select low: B bus follows A bus live
// - both enables high, B select high: B bus shows A-to-B register
// - B enable high, A enable low, both selects high: both buses from registers
// - both enables high, B select low, both clocks rising: A value lands in both registers
// - both enables low, A select low, both clocks rising: B value lands in both registers
// - real-time selects with both directions enabled make buses hold their state
// - select changes between stored and live data without output glitch
// - eight identical bit channels sharing the common controls
package rbt_pkg;
  // data width of each bus
  localparam int RBT_WIDTH = 8;
  // depth of the capture fifo on the b-to-a path
  localparam int RBT_FIFO_DEPTH = 16;
  // value of every data register in the transceiver after reset, except the fifo storage array
  localparam logic [7:0] RBT_DATA_RESET = 8'h00;
  // pipeline stages of every pin synchroniser
  localparam int RBT_SYNC_STAGES = 2;
endpackage

/* File: logic/rbt_fifo.sv */
// small synchronous fifo with valid/ready on both sides
module rbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready_o = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage array, written only on a taken push
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

/* File: logic/rbt_transceiver.sv */
// registered eight-bit bus transceiver between bus a and bus b
module rbt_transceiver (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic drive_b_bus_enable_i,
  input wire logic drive_a_bus_enable_low_i,
  input wire logic b_bus_source_select_i,
  input wire logic a_bus_source_select_i,
  input wire logic a_side_capture_clock_i,
  input wire logic b_side_capture_clock_i,
  input wire logic [7:0] a_bus_i,
  output logic [7:0] a_bus_o,
  output logic a_bus_oe_o,
  input wire logic [7:0] b_bus_i,
  output logic [7:0] b_bus_o,
  output logic b_bus_oe_o,
  output logic [7:0] b_capture_data_o,
  output logic b_capture_valid_o,
  input wire logic b_capture_ready_i,
  output logic b_capture_overflow_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] a_meta_reg;
  logic [7:0] a_sync_reg;
  logic [7:0] b_meta_reg;
  logic [7:0] b_sync_reg;
  logic [5:0] ctl_meta_reg;
  logic [5:0] ctl_sync_reg;
  logic cap_a_last_reg;
  logic cap_b_last_reg;

  // bus a pins: two flops, only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      a_meta_reg <= rbt_pkg::RBT_DATA_RESET;
      a_sync_reg <= rbt_pkg::RBT_DATA_RESET;
    end
    else
    begin
      a_meta_reg <= a_bus_i;
      a_sync_reg <= a_meta_reg;
    end
  end

  // bus b pins, same depth so both buses line up in time
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      b_meta_reg <= rbt_pkg::RBT_DATA_RESET;
      b_sync_reg <= rbt_pkg::RBT_DATA_RESET;
    end
    else
    begin
      b_meta_reg <= b_bus_i;
      b_sync_reg <= b_meta_reg;
    end
  end

  // control pins; a one-clock skew between them is accepted,
  // since every control is a level held for several clocks
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctl_meta_reg <= 6'h00;
      ctl_sync_reg <= 6'h00;
    end
    else
    begin
      ctl_meta_reg <= {drive_b_bus_enable_i, drive_a_bus_enable_low_i, b_bus_source_select_i,
                       a_bus_source_select_i, a_side_capture_clock_i, b_side_capture_clock_i};
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  // ****************************************
  // control decode
  // ****************************************
  logic en_b;
  logic en_a_low;
  logic sel_b;
  logic sel_a;
  logic cap_a;
  logic cap_b;
  assign en_b = ctl_sync_reg[5];
  assign en_a_low = ctl_sync_reg[4];
  assign sel_b = ctl_sync_reg[3];
  assign sel_a = ctl_sync_reg[2];
  assign cap_a = ctl_sync_reg[1];
  assign cap_b = ctl_sync_reg[0];

  // ****************************************
  // capture edge detection
  // ****************************************
  logic rise_a;
  logic rise_b;
  assign rise_a = cap_a && !cap_a_last_reg;
  assign rise_b = cap_b && !cap_b_last_reg;

  // previous level of the a-side capture clock; low after reset like the idle pin
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cap_a_last_reg <= 1'b0;
    end
    else
    begin
      cap_a_last_reg <= cap_a;
    end
  end

  // previous level of the b-side capture clock
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cap_b_last_reg <= 1'b0;
    end
    else
    begin
      cap_b_last_reg <= cap_b;
    end
  end

  // ****************************************
  // wire level seen at the pins
  // ****************************************
  // when we drive a bus, the pin carries our own value, so a capture
  // taken then sees what we drive; this is how both-register loads arise
  logic [7:0] a_seen;
  logic [7:0] b_seen;
  logic [7:0] a_drive;
  logic [7:0] b_drive;
  logic [7:0] ab_store_reg;
  logic [7:0] ba_store_reg;
  logic a_drv_on;
  logic b_drv_on;

  assign a_drv_on = !en_a_low;
  assign b_drv_on = en_b;

  // the synchronised pin value already reflects our own drive on a shared
  // wire, so a driven bus reads back its source; this hold intact
  assign a_seen = a_sync_reg;
  assign b_seen = b_sync_reg;

  // per-bit source select, applied to all eight channels alike
  function automatic logic [7:0] rbt_pick(input logic sel, input logic [7:0] live, input logic [7:0] stored);
    rbt_pick = sel ? stored : live;
  endfunction

  // capture source: a bus we drive live from the far side carries the
  // far value, so it is taken directly rather than after the read-back lag
  function automatic logic [7:0] rbt_cap_src(input logic driven, input logic sel, input logic [7:0] own,
    input logic [7:0] far);
    rbt_cap_src = (driven && !sel) ? far : own;
  endfunction

  // ****************************************
  // capture sources
  // ****************************************
  logic [7:0] ab_load_val;
  logic [7:0] ba_load_val;
  assign ab_load_val = rbt_cap_src(a_drv_on, sel_a, a_seen, b_seen);
  assign ba_load_val = rbt_cap_src(b_drv_on, sel_b, b_seen, a_seen);

  // ****************************************
  // storage registers
  // ****************************************
  // a-to-b register loads on a-side capture edge regardless of selects
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ab_store_reg <= rbt_pkg::RBT_DATA_RESET;
    end
    else if (rise_a)
    begin
      ab_store_reg <= ab_load_val;
    end
    // no edge: content held
  end

  // b-to-a register; when bus b is driven from a, b_seen is the a value
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ba_store_reg <= rbt_pkg::RBT_DATA_RESET;
    end
    else if (rise_b)
    begin
      ba_store_reg <= ba_load_val;
    end
  end

  // ****************************************
  // output path
  // ****************************************
  // source select per direction, shared by all eight channels
  assign a_drive = rbt_pick(sel_a, b_seen, ba_store_reg);
  assign b_drive = rbt_pick(sel_b, a_seen, ab_store_reg);

  // ****************************************
  // bus a driver
  // ****************************************
  // mux output sampled once a clock, so a select change moves the
  // pin in one clean step with no decoding glitch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      a_bus_o <= rbt_pkg::RBT_DATA_RESET;
    end
    else
    begin
      a_bus_o <= a_drive;
    end
  end

  // a enable follows the active-low pin; released during reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      a_bus_oe_o <= 1'b0;
    end
    else
    begin
      a_bus_oe_o <= a_drv_on;
    end
  end

  // ****************************************
  // bus b driver
  // ****************************************
  // same registered mux as bus a, for the same glitch-free switch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      b_bus_o <= rbt_pkg::RBT_DATA_RESET;
    end
    else
    begin
      b_bus_o <= b_drive;
    end
  end

  // b enable follows the active-high pin; released during reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      b_bus_oe_o <= 1'b0;
    end
    else
    begin
      b_bus_oe_o <= b_drv_on;
    end
  end

  // ****************************************
  // capture stream of b-side loads
  // ****************************************
  // every b-side capture also enters a fifo; a full fifo drops the word
  // and raises a sticky flag, since a capture edge cannot be stalled
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  rbt_fifo #(
    .WIDTH(rbt_pkg::RBT_WIDTH),
    .DEPTH(rbt_pkg::RBT_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(rise_b),
    .in_ready_o(fifo_in_ready),
    .in_data_i(ba_load_val),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!b_capture_valid_o || b_capture_ready_i),
    .out_data_o(fifo_out_data)
  );

  // output stage refills when empty or when its word is taken; valid
  // never waits on ready, so a consumer that waits on valid cannot stall
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      b_capture_valid_o <= 1'b0;
      b_capture_data_o <= rbt_pkg::RBT_DATA_RESET;
    end
    else if (!b_capture_valid_o || b_capture_ready_i)
    begin
      b_capture_valid_o <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        b_capture_data_o <= fifo_out_data;
      end
    end
  end

  // ****************************************
  // overflow report
  // ****************************************
  // sticky overflow flag, cleared only by reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      b_capture_overflow_o <= 1'b0;
    end
    else if (rise_b && !fifo_in_ready)
    begin
      b_capture_overflow_o <= 1'b1;
    end
  end
endmodule

/* File: tb/rbt_bus_partner.sv */
// far-side bus drivers for the transceiver bench
module rbt_bus_partner (
  input wire logic clk_i,
  input wire logic a_drive_i,
  input wire logic [7:0] a_value_i,
  input wire logic b_drive_i,
  input wire logic [7:0] b_value_i,
  input wire logic [7:0] a_bus_o,
  input wire logic a_bus_oe_o,
  input wire logic [7:0] b_bus_o,
  input wire logic b_bus_oe_o,
  output logic [7:0] a_bus_i,
  output logic [7:0] b_bus_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] a_last_reg, b_last_reg;
  // floating bus shows the inverse of its last level, so stale data never passes
  always_ff @(posedge clk_i)
  begin
    a_last_reg <= a_bus_i;
    b_last_reg <= b_bus_i;
  end
  // device drive wins and is read back on its own pins
  assign a_bus_i = a_bus_oe_o ? a_bus_o : (a_drive_i ? a_value_i : ~a_last_reg);
  assign b_bus_i = b_bus_oe_o ? b_bus_o : (b_drive_i ? b_value_i : ~b_last_reg);
endmodule

/* File: tb/rbt_transceiver_properties.sv */
// port checker for the registered bus transceiver
module rbt_transceiver_properties (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic drive_b_bus_enable_i,
  input wire logic drive_a_bus_enable_low_i,
  input wire logic b_bus_source_select_i,
  input wire logic a_bus_source_select_i,
  input wire logic a_side_capture_clock_i,
  input wire logic b_side_capture_clock_i,
  input wire logic [7:0] a_bus_i,
  input wire logic [7:0] a_bus_o,
  input wire logic a_bus_oe_o,
  input wire logic [7:0] b_bus_i,
  input wire logic [7:0] b_bus_o,
  input wire logic b_bus_oe_o,
  input wire logic [7:0] b_capture_data_o,
  input wire logic b_capture_valid_o,
  input wire logic b_capture_ready_i
);
  logic [2:0] up_reg;
  logic settled;
  // edges since reset, so $past never looks back into reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      up_reg <= 3'h0;
    else if (!settled)
      up_reg <= up_reg + 3'h1;
  end
  assign settled = (up_reg == 3'h6);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence seq_b_held;
    (settled && b_bus_source_select_i && b_bus_oe_o && $stable(a_side_capture_clock_i))[*6];
  endsequence
  sequence seq_a_cap;
    settled && $rose(a_side_capture_clock_i) ##1 ($stable(a_bus_i) && b_bus_source_select_i
      && drive_b_bus_enable_i && (drive_a_bus_enable_low_i || a_bus_source_select_i))[*4];
  endsequence
  sequence seq_b_cap;
    settled && $rose(b_side_capture_clock_i) ##1 ($stable(b_bus_i) && a_bus_source_select_i
      && !drive_a_bus_enable_low_i && (!drive_b_bus_enable_i || b_bus_source_select_i))[*4];
  endsequence
  AST_OE_B: assert property (settled |-> b_bus_oe_o == $past(drive_b_bus_enable_i, 3))
    else $error("b drive enable wrong");
  AST_OE_A: assert property (settled |-> a_bus_oe_o == !$past(drive_a_bus_enable_low_i, 3))
    else $error("a drive enable wrong");
  AST_LIVE_B: assert property (settled && b_bus_oe_o && !$past(b_bus_source_select_i, 3)
    && !$past(b_bus_source_select_i, 4) |-> b_bus_o == $past(a_bus_i, 3))
    else $error("b bus not live a");
  AST_LIVE_A: assert property (settled && a_bus_oe_o && !$past(a_bus_source_select_i, 3)
    && !$past(a_bus_source_select_i, 4) |-> a_bus_o == $past(b_bus_i, 3))
    else $error("a bus not live b");
  AST_B_HOLD: assert property (seq_b_held |-> $stable(b_bus_o))
    else $error("stored b output moved");
  AST_A_STORE: assert property (seq_a_cap |-> b_bus_o == $past(a_bus_i, 4))
    else $error("a capture not shown");
  AST_B_STORE: assert property (seq_b_cap |-> a_bus_o == $past(b_bus_i, 4))
    else $error("b capture not shown");
  AST_CAP_STAND: assert property (b_capture_valid_o && !b_capture_ready_i
    |=> b_capture_valid_o && $stable(b_capture_data_o))
    else $error("capture word dropped");
endmodule
bind rbt_transceiver rbt_transceiver_properties rbt_transceiver_properties_inst (.*);

/* File: tb/tb_rbt_transceiver.sv */
// self-checking bench for the registered bus transceiver
module tb_rbt_transceiver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, b_capture_ready_i = 1'b1;
  logic drive_b_bus_enable_i = 1'b0, drive_a_bus_enable_low_i = 1'b1;
  logic b_bus_source_select_i = 1'b0, a_bus_source_select_i = 1'b0;
  logic a_side_capture_clock_i = 1'b0, b_side_capture_clock_i = 1'b0;
  logic a_drive_i = 1'b1, b_drive_i = 1'b1;
  logic [7:0] a_value_i = 8'h00, b_value_i = 8'h00;
  logic [7:0] a_bus_i, a_bus_o, b_bus_i, b_bus_o, b_capture_data_o;
  logic a_bus_oe_o, b_bus_oe_o, b_capture_valid_o, b_capture_overflow_o;
  int bad_count = 0, samples_checked = 0;
  rbt_transceiver rbt_transceiver_inst (.*);
  rbt_bus_partner rbt_bus_partner_inst (.*);
  always #25 clk_i = ~clk_i;
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // controls and far drivers change together, then settle past the sync delay
  task automatic set(input logic [3:0] c, input logic ad, input logic [7:0] av, input logic bd,
    input logic [7:0] bv);
    @(posedge clk_i);
    {drive_b_bus_enable_i, drive_a_bus_enable_low_i, b_bus_source_select_i, a_bus_source_select_i} <= c;
    {a_drive_i, a_value_i, b_drive_i, b_value_i} <= {ad, av, bd, bv};
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // capture clock levels held well over two cycles each
  task automatic cap(input logic a, input logic b);
    @(posedge clk_i);
    {a_side_capture_clock_i, b_side_capture_clock_i} <= {a, b};
    repeat (3) @(posedge clk_i);
    {a_side_capture_clock_i, b_side_capture_clock_i} <= 2'b00;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic both_out(input logic [7:0] ea, input logic [7:0] eb);
    set(4'b1011, 1'b0, 8'h00, 1'b0, 8'h00);
    chk(a_bus_o, ea);
    chk(b_bus_o, eb);
  endtask
  task automatic results;
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_paths;
    set(4'b0100, 1'b1, 8'h11, 1'b1, 8'h22);
    chk(8'(a_bus_oe_o), 8'h00);
    chk(8'(b_bus_oe_o), 8'h00);
    set(4'b1100, 1'b1, 8'hA5, 1'b0, 8'h00);
    chk(b_bus_o, 8'hA5);
    chk(8'(b_bus_oe_o), 8'h01);
    set(4'b1100, 1'b1, 8'h5A, 1'b0, 8'h00);
    chk(b_bus_o, 8'h5A);
    cap(1'b1, 1'b0);
    set(4'b1110, 1'b1, 8'hC3, 1'b0, 8'h00);
    chk(b_bus_o, 8'h5A);
    cap(1'b1, 1'b0);
    chk(b_bus_o, 8'hC3);
    set(4'b0000, 1'b0, 8'h00, 1'b1, 8'h96);
    chk(a_bus_o, 8'h96);
    cap(1'b0, 1'b1);
    set(4'b0001, 1'b0, 8'h00, 1'b1, 8'h69);
    chk(a_bus_o, 8'h96);
    cap(1'b0, 1'b1);
    chk(a_bus_o, 8'h69);
    both_out(8'h69, 8'hC3);
  endtask
  task automatic t_hold;
    // b follows a, then a is enabled while still driven, then released
    set(4'b1100, 1'b1, 8'h77, 1'b0, 8'h00);
    set(4'b1000, 1'b1, 8'h77, 1'b0, 8'h00);
    set(4'b1000, 1'b0, 8'h00, 1'b0, 8'h00);
    repeat (8) @(negedge clk_i);
    chk(a_bus_o, 8'h77);
    chk(b_bus_o, 8'h77);
  endtask
  // selects low here, so both capture clocks may rise together
  task automatic t_both_clocks;
    set(4'b1100, 1'b1, 8'hE1, 1'b0, 8'h00);
    cap(1'b1, 1'b1);
    both_out(8'hE1, 8'hE1);
    set(4'b0000, 1'b0, 8'h00, 1'b1, 8'h1E);
    cap(1'b1, 1'b1);
    both_out(8'h1E, 8'h1E);
  endtask
  task automatic t_fifo;
    int k;
    @(posedge clk_i);
    b_capture_ready_i <= 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      set(4'b0100, 1'b0, 8'h00, 1'b1, 8'(i));
      cap(1'b0, 1'b1);
    end
    chk(8'(b_capture_overflow_o), 8'h01);
    @(posedge clk_i);
    b_capture_ready_i <= 1'b1;
    for (int j = 0; j < 17; j++)
    begin
      k = 0;
      @(negedge clk_i);
      while (b_capture_valid_o !== 1'b1 && k < 6)
      begin
        @(negedge clk_i);
        k++;
      end
      chk(b_capture_data_o, 8'(j));
      @(posedge clk_i);
    end
    repeat (4) @(negedge clk_i);
    chk(8'(b_capture_valid_o), 8'h00);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_paths();
    t_hold();
    t_both_clocks();
    t_fifo();
    results();
  end
  // watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule
